// File: core/nbs_host.sv
// Purpose: host side sequencer driving an asynchronous nand flash bus
// Assumes: rb_i and io_i are synchronous to clock; one flash on the bus
// Notes:   one command at a time; strobes are built from clock counts
// Notes on behaviour
// - command latched: cle high, ale low, re high
// - write protect held high during program sequences
// - address latched: ale high, cle low, four cycles, two for random output
// - program data latched: cle ale low, wp high
// - data out by read strobe, chip select held
// - below 30ns cycle, sample on next fall
// - strobes stay high while flash is busy
// - page read is 00h, address, 30h, busy
// - random output only after a page loaded
// - page read before 31h, 31h before 3fh
// - at most four partial programs per page
// - pages in a block programmed in ascending order
// - program is 80h, address, data, 10h
// - address bytes: column, page, block, low first
`timescale 1ns/1ns
module nbs_host #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // user command port
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire nbs_pkg::nbs_cmd_t cmd,
  output logic              done,
  output logic              err,
  // program data stream
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [7:0]   wr_data,
  // read data stream
  output logic              rd_valid,
  output logic [7:0]        rd_data,
  // flash pins
  output nbs_pkg::nbs_pins_t pins,
  input  wire logic [7:0]   io_i,
  input  wire logic         rb_i
);
  import nbs_pkg::*;

  nbs_core_t  s;
  nbs_core_t  n;
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       pop;
  logic       bad;
  logic       is_wr;
  logic       hi_end;
  logic       same_blk;

  // program data waits here while the bus is mid strobe
  nbs_skid_buf #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  assign cmd_ready = (s.st == ST_IDLE);
  assign done      = s.done;
  assign err       = s.err;
  assign rd_valid  = s.rd_valid;
  assign rd_data   = s.rd_data;
  assign pins      = s.pins;

  // legality of a new command against what the flash holds
  always_comb begin
    same_blk = s.pvalid && (cmd.addr[27:BLK_LSB] == s.pblk);
    bad = 1'b0;
    unique case (cmd.op)
      OP_READ:      bad = (cmd.len > PAGE_BYTES);
      OP_CACHE:     bad = !s.loaded;
      OP_CACHE_END: bad = !s.cached;
      OP_RAND:      bad = !s.loaded;
      OP_PROG: begin
        bad = (cmd.len == 12'h0) || (cmd.len > PROG_MAX);
        if (same_blk && cmd.addr[17:PAGE_LSB] < s.ppage) begin
          bad = 1'b1;
        end
        if (same_blk && cmd.addr[17:PAGE_LSB] == s.ppage &&
            s.pcount == PART_MAX) begin
          bad = 1'b1;
        end
      end
      default:      bad = 1'b1;
    endcase
  end

  assign is_wr  = (s.st == ST_CMD1) || (s.st == ST_ADDR) ||
                  (s.st == ST_DATA_IN) || (s.st == ST_CMD2);
  assign hi_end = is_wr && (s.cnt == 4'h0) && (s.ph == PH_HIGH);

  // main sequencer; every write strobe is setup, low, high
  always_comb begin
    n = s;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    n.err = 1'b0;
    pop = 1'b0;
    if (is_wr && s.cnt != 4'h0) begin
      n.cnt = s.cnt - 4'h1;
    end else if (is_wr && s.ph == PH_LOW) begin
      n.pins.we_n = 1'b1;
      n.ph = PH_HIGH;
      n.cnt = STROBE_CNT;
    end else if (is_wr && s.ph == PH_SETUP && s.st != ST_DATA_IN) begin
      n.pins.we_n = 1'b0;
      n.ph = PH_LOW;
      n.cnt = STROBE_CNT;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (cmd_valid && bad) begin
          n.done = 1'b1;
          n.err = 1'b1;
        end else if (cmd_valid) begin
          n.op = cmd.op;
          n.addr = cmd.addr;
          n.len = cmd.len;
          n.idx = 12'h0;
          n.abyte = 2'h0;
          n.pins.ce_n = 1'b0;
          n.pins.cle = 1'b1;
          n.pins.io_oe = 1'b1;
          n.pins.wp_n = (cmd.op == OP_PROG);
          unique case (cmd.op)
            OP_CACHE:     n.pins.io_o = CMD_CACHE;
            OP_CACHE_END: n.pins.io_o = CMD_CACHE_END;
            OP_RAND:      n.pins.io_o = CMD_RAND;
            OP_PROG:      n.pins.io_o = CMD_PROG;
            default:      n.pins.io_o = CMD_READ;
          endcase
          n.ph = PH_SETUP;
          n.st = ST_CMD1;
        end
      end
      ST_CMD1: begin
        if (hi_end && (s.op == OP_CACHE || s.op == OP_CACHE_END)) begin
          n.st = ST_WAIT;
          n.pins.cle = 1'b0;
          n.pins.io_oe = 1'b0;
          n.cnt = WB_CNT;
        end else if (hi_end) begin
          n.st = ST_ADDR;
          n.pins.cle = 1'b0;
          n.pins.ale = 1'b1;
          n.pins.io_o = addr_byte(s.addr, 2'h0);
          n.ph = PH_SETUP;
        end
      end
      ST_ADDR: begin
        if (hi_end && (s.abyte == 2'h3 ||
            (s.op == OP_RAND && s.abyte == 2'h1))) begin
          n.pins.ale = 1'b0;
          n.ph = PH_SETUP;
          if (s.op == OP_PROG) begin
            n.st = ST_DATA_IN;
          end else begin
            n.st = ST_CMD2;
            n.pins.cle = 1'b1;
            n.pins.io_o = (s.op == OP_RAND) ? CMD_RAND_GO : CMD_READ_GO;
          end
        end else if (hi_end) begin
          n.abyte = s.abyte + 2'h1;
          n.pins.io_o = addr_byte(s.addr, s.abyte + 2'h1);
          n.ph = PH_SETUP;
        end
      end
      ST_DATA_IN: begin
        if (s.ph == PH_SETUP && s.idx == s.len) begin
          n.st = ST_CMD2;
          n.pins.cle = 1'b1;
          n.pins.io_o = CMD_PROG_GO;
        end else if (s.ph == PH_SETUP && buf_valid) begin
          pop = 1'b1;
          n.pins.io_o = buf_data;
          n.pins.we_n = 1'b0;
          n.ph = PH_LOW;
          n.cnt = STROBE_CNT;
          n.idx = s.idx + 12'h1;
        end else if (hi_end) begin
          n.ph = PH_SETUP;
        end
      end
      ST_CMD2: begin
        if (hi_end) begin
          n.st = ST_WAIT;
          n.pins.cle = 1'b0;
          n.pins.io_oe = 1'b0;
          n.cnt = WB_CNT;
        end
      end
      ST_WAIT: begin
        // strobes stay high here; busy reads are not yet valid
        if (s.cnt != 4'h0) begin
          n.cnt = s.cnt - 4'h1;
        end else if (rb_i) begin
          n.idx = 12'h0;
          n.ph = PH_SETUP;
          n.st = (s.op == OP_PROG || s.len == 12'h0) ? ST_DONE : ST_DATA_OUT;
        end
      end
      ST_DATA_OUT: begin
        // a 70ns read cycle is slow enough to sample before the rise
        if (s.cnt != 4'h0) begin
          n.cnt = s.cnt - 4'h1;
        end else begin
          unique case (s.ph)
            PH_SETUP: begin
              n.pins.re_n = 1'b0;
              n.ph = PH_LOW;
              n.cnt = STROBE_CNT;
            end
            PH_LOW: begin
              n.rd_data = io_i;
              n.rd_valid = 1'b1;
              n.pins.re_n = 1'b1;
              n.ph = PH_HIGH;
              n.cnt = STROBE_CNT;
            end
            PH_HIGH: begin
              n.idx = s.idx + 12'h1;
              n.ph = PH_SETUP;
              n.st = (s.idx + 12'h1 == s.len) ? ST_DONE : ST_DATA_OUT;
            end
            default: n.ph = PH_SETUP;
          endcase
        end
      end
      ST_DONE: begin
        n.pins.ce_n = 1'b1;
        n.pins.wp_n = 1'b0;
        n.done = 1'b1;
        n.st = ST_IDLE;
        unique case (s.op)
          OP_READ: begin
            n.loaded = 1'b1;
            n.cached = 1'b0;
          end
          OP_CACHE:     n.cached = 1'b1;
          OP_CACHE_END: n.cached = 1'b0;
          OP_PROG: begin
            n.loaded = 1'b0;
            n.cached = 1'b0;
            n.pvalid = 1'b1;
            n.pblk = s.addr[27:BLK_LSB];
            n.ppage = s.addr[17:PAGE_LSB];
            n.pcount = (s.pvalid && s.addr[27:PAGE_LSB] ==
                        {s.pblk, s.ppage}) ? s.pcount + 3'h1 : 3'h1;
          end
          default: n.loaded = s.loaded;
        endcase
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  // checks on the pins this module drives
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_CMD_LATCH: assert property (
    $rose(s.pins.we_n) && s.pins.cle |->
      !s.pins.ce_n && !s.pins.ale && s.pins.re_n)
    else $error("command latched with wrong control levels");
  AST_ADDR_LATCH: assert property (
    $rose(s.pins.we_n) && s.pins.ale |->
      !s.pins.ce_n && !s.pins.cle && s.pins.re_n)
    else $error("address latched with wrong control levels");
  AST_DATA_LATCH: assert property (
    $rose(s.pins.we_n) && s.st == ST_DATA_IN |->
      !s.pins.ce_n && !s.pins.cle && !s.pins.ale && s.pins.wp_n)
    else $error("program data latched with wrong control levels");
  AST_WP_PROG: assert property (
    s.op == OP_PROG && s.st != ST_IDLE && s.st != ST_DONE |-> s.pins.wp_n)
    else $error("write protect low during program");
  AST_WE_WIDTH: assert property (
    $fell(s.pins.we_n) |=> !s.pins.we_n ##1 !s.pins.we_n ##1 s.pins.we_n)
    else $error("write strobe low time wrong");
  AST_RE_WIDTH: assert property (
    $fell(s.pins.re_n) |-> !s.pins.ce_n ##1 !s.pins.re_n ##1 !s.pins.re_n
      ##1 (s.pins.re_n && s.rd_valid))
    else $error("read strobe cycle wrong");
  AST_BUSY_QUIET: assert property (
    s.st == ST_WAIT |-> s.pins.we_n && s.pins.re_n)
    else $error("strobe active while waiting on busy");
  AST_NO_EMPTY_PROG: assert property (
    s.st == ST_CMD2 && s.op == OP_PROG |-> s.idx != 12'h0)
    else $error("program confirm without data");
  AST_CACHE_END_ORDER: assert property (
    $rose(s.st == ST_CMD1) && s.op == OP_CACHE_END |-> s.cached)
    else $error("cache end without cache read");

  COV_READ: cover property (s.st == ST_DONE && s.op == OP_READ);
  COV_PROG: cover property (s.st == ST_DONE && s.op == OP_PROG);
  COV_CACHE_END: cover property (s.st == ST_DONE && s.op == OP_CACHE_END);
  COV_BUF_FULL: cover property (wr_valid && !wr_ready);

endmodule

// File: core/nbs_pkg.sv
// Purpose: shared types and constants of the nand bus sequencer host
// Assumes: byte-wide flash bus, 100 MHz system clock
// Notes:   all counts are derived from times given in nanoseconds
package nbs_pkg;

  // clock and bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_STROBE_NS   = 25;   // least low or high time of a strobe
  localparam int T_WB_NS       = 100;  // least wait before busy is valid
  localparam int STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC - 1);
  localparam logic [3:0] WB_CNT     = 4'(WB_CYC - 1);

  // array geometry and program limits
  localparam logic [11:0] PAGE_BYTES = 12'h880;  // 2176 bytes per page
  localparam logic [11:0] PROG_MAX   = 12'h840;  // 2112 bytes per program
  localparam logic [2:0]  PART_MAX   = 3'h4;     // partial programs per page
  localparam int COL_LSB  = 0;
  localparam int PAGE_LSB = 12;
  localparam int BLK_LSB  = 18;

  // command bytes
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_READ_GO   = 8'h30;
  localparam logic [7:0] CMD_RAND      = 8'h05;
  localparam logic [7:0] CMD_RAND_GO   = 8'he0;
  localparam logic [7:0] CMD_CACHE     = 8'h31;
  localparam logic [7:0] CMD_CACHE_END = 8'h3f;
  localparam logic [7:0] CMD_PROG      = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;

  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_CACHE     = 3'h1,
    OP_CACHE_END = 3'h2,
    OP_RAND      = 3'h3,
    OP_PROG      = 3'h4
  } nbs_op_t;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_CMD1     = 8'h02,
    ST_ADDR     = 8'h04,
    ST_DATA_IN  = 8'h08,
    ST_CMD2     = 8'h10,
    ST_WAIT     = 8'h20,
    ST_DATA_OUT = 8'h40,
    ST_DONE     = 8'h80
  } nbs_state_t;

  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_LOW   = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;

  typedef struct packed {
    nbs_op_t     op;
    logic [27:0] addr;   // column 11:0, page 17:12, block 27:18
    logic [11:0] len;    // bytes to read or to program
  } nbs_cmd_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic       io_oe;
    logic [7:0] io_o;
  } nbs_pins_t;

  typedef struct packed {
    nbs_state_t  st;
    logic [1:0]  ph;
    logic [3:0]  cnt;
    nbs_op_t     op;
    logic [27:0] addr;
    logic [11:0] len;
    logic [11:0] idx;
    logic [1:0]  abyte;
    nbs_pins_t   pins;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        done;
    logic        err;
    logic        loaded;
    logic        cached;
    logic        pvalid;
    logic [9:0]  pblk;
    logic [5:0]  ppage;
    logic [2:0]  pcount;
  } nbs_core_t;

  localparam nbs_pins_t PINS_RST = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
                                     we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0,
                                     io_oe: 1'b0, io_o: 8'h00};

  localparam nbs_core_t CORE_RST = '{st: ST_IDLE, ph: PH_SETUP,
    cnt: 4'h0, op: OP_READ, addr: 28'h0, len: 12'h0, idx: 12'h0,
    abyte: 2'h0, pins: PINS_RST, rd_data: 8'h00, rd_valid: 1'b0,
    done: 1'b0, err: 1'b0, loaded: 1'b0, cached: 1'b0, pvalid: 1'b0,
    pblk: 10'h0, ppage: 6'h0, pcount: 3'h0};

  // address byte n, least significant first, column padded to 16 bits
  function automatic logic [7:0] addr_byte(logic [27:0] a, logic [1:0] n);
    logic [7:0] b;
    b = 8'h00;
    unique case (n)
      2'h0: b = a[7:0];
      2'h1: b = {4'h0, a[11:8]};
      2'h2: b = a[19:12];
      2'h3: b = a[27:20];
    endcase
    return b;
  endfunction

endpackage

// File: core/nbs_skid_buf.sv
// Purpose: small valid/ready buffer in the program data path
// Assumes: single clock, push and pop may happen in one cycle
// Notes:   output data comes straight from the storage flops
`timescale 1ns/1ns
module nbs_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } nbs_buf_t;

  nbs_buf_t s_r;
  nbs_buf_t s_nxt;
  logic     push;
  logic     pop;

  // ready drops only when every entry holds a word
  assign in_ready  = (s_r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer wrap and occupancy
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == PW'(DEPTH-1)) ? '0 : s_r.wp + PW'(1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == PW'(DEPTH-1)) ? '0 : s_r.rp + PW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + (PW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - (PW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// File: tb/nbs_flash_model.sv
// Purpose: behavioural flash on the far side of the bus sequencer
// Assumes: pins are registered on clock, so edges are seen per cycle
// Notes:   busy length comes from the bench so busy can be short or long
`timescale 1ns/1ns
module nbs_flash_model (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               arst_n,
  // host pins and busy length
  input  wire nbs_pkg::nbs_pins_t pins,
  input  wire logic [7:0]         busy_len,
  // flash answers
  output logic [7:0]              io_d,
  output logic                    rb,
  // capture log and protocol violations
  output logic                    cap_v,
  output logic [1:0]              cap_k,
  output logic [7:0]              cap_b,
  output logic                    viol
);
  import nbs_pkg::*;
  logic        we_q, re_q, prog;
  logic [7:0]  last_d, bcnt;
  logic [31:0] ab;
  logic [1:0]  acnt;
  logic [15:0] drow, orow;
  logic [11:0] col, ndata;
  wire         live  = !pins.ce_n;
  wire         wrise = live && !we_q && pins.we_n && pins.re_n;

  function automatic logic [7:0] pat(logic [15:0] r, logic [11:0] c);
    return r[7:0] ^ r[15:8] ^ c[7:0] ^ {4'h0, c[11:8]};
  endfunction

  // a released bus shows the inverse of the last byte, never a kind value
  assign io_d = (live && !pins.re_n) ? pat(orow, col) : ~last_d;
  assign rb   = (bcnt == 8'h00);

  // bus capture and page register sequencing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      we_q   <= 1'b1;
      re_q   <= 1'b1;
      prog   <= 1'b0;
      last_d <= 8'h00;
      bcnt   <= 8'h00;
      ab     <= 32'h0;
      acnt   <= 2'h0;
      col    <= 12'h000;
      drow   <= 16'h0000;
      orow   <= 16'h0000;
      ndata  <= 12'h000;
      cap_v  <= 1'b0;
      cap_k  <= 2'h0;
      cap_b  <= 8'h00;
      viol   <= 1'b0;
    end else begin
      we_q  <= pins.we_n;
      re_q  <= pins.re_n;
      cap_v <= 1'b0;
      // strobes must rest while busy; no fight on the data lines
      viol  <= (!rb && (!pins.we_n || !pins.re_n)) ||
               (pins.io_oe && live && !pins.re_n);
      if (bcnt != 8'h00) bcnt <= bcnt - 8'h01;
      if (live && !pins.re_n) last_d <= io_d;
      if (live && !re_q && pins.re_n) col <= col + 12'h001;
      if (!pins.wp_n) prog <= 1'b0;
      if (wrise && pins.cle && !pins.ale) begin
        cap_v <= 1'b1;
        cap_k <= 2'h0;
        cap_b <= pins.io_o;
        acnt  <= 2'h0;
        if (!pins.wp_n && (pins.io_o == 8'h80 || pins.io_o == 8'h10))
          viol <= 1'b1;
        case (pins.io_o)
          8'h30: begin
            drow <= ab[31:16];
            orow <= ab[31:16];
            col  <= ab[11:0];
            bcnt <= busy_len;
          end
          8'he0: col <= ab[11:0];
          8'h31: begin
            orow <= drow;
            drow <= drow + 16'h0001;
            col  <= 12'h000;
            bcnt <= busy_len;
          end
          8'h3f: begin
            orow <= drow;
            col  <= 12'h000;
            bcnt <= busy_len;
          end
          8'h80: begin
            prog  <= pins.wp_n;
            ndata <= 12'h000;
          end
          8'h10: begin
            if (prog && ndata != 12'h000) bcnt <= busy_len;
            prog <= 1'b0;
          end
          default: ;
        endcase
      end
      if (wrise && pins.ale && !pins.cle) begin
        cap_v <= 1'b1;
        cap_k <= 2'h1;
        cap_b <= pins.io_o;
        ab[8*acnt +: 8] <= pins.io_o;
        acnt <= acnt + 2'h1;
      end
      if (wrise && !pins.ale && !pins.cle && pins.wp_n) begin
        cap_v <= 1'b1;
        cap_k <= 2'h2;
        cap_b <= pins.io_o;
        ndata <= ndata + 12'h001;
      end
    end
  end
endmodule

// File: tb/nbs_host_tb.sv
// Purpose: self-checking bench for the nand bus sequencer host
// Assumes: flash model answers with a byte pattern of row and column
// Notes:   expected events are queued in order and popped by a monitor
`timescale 1ns/1ns
module nbs_host_tb;
  import nbs_pkg::*;
  typedef struct packed {
    logic [2:0] k;
    logic [7:0] b;
  } nbs_ev_t;

  logic        clock, arst_n, cmd_valid, cmd_ready, done, err;
  logic        wr_valid, wr_ready, rd_valid, rb, cap_v, viol;
  logic [7:0]  wr_data, rd_data, io_d, cap_b, busy_len;
  logic [1:0]  cap_k;
  nbs_cmd_t    cmd;
  nbs_pins_t   pins;
  nbs_ev_t     q[$];
  logic [7:0]  wq[$], pend[$];
  int          n_fail, n_tests, i;
  logic [15:0] drow, orow;
  logic [27:0] a;
  wire  [7:0]  io_i = pins.io_oe ? pins.io_o : io_d;

  nbs_host i_dut (.clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .done(done), .err(err),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .io_i(io_i),
    .rb_i(rb));
  nbs_flash_model i_flash (.clock(clock), .arst_n(arst_n), .pins(pins),
    .busy_len(busy_len), .io_d(io_d), .rb(rb), .cap_v(cap_v),
    .cap_k(cap_k), .cap_b(cap_b), .viol(viol));

  always #5 clock = ~clock;

  function automatic logic [7:0] pat(logic [15:0] r, logic [11:0] c);
    return r[7:0] ^ r[15:8] ^ c[7:0] ^ {4'h0, c[11:8]};
  endfunction

  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bad(string m);
    n_fail++;
    $display("unexpected %0t %s", $time, m);
  endtask

  task automatic ex(logic [2:0] k, logic [7:0] b);
    q.push_back('{k: k, b: b});
  endtask

  // address bytes: column low, column high nibble, then row low first
  task automatic addr4(logic [27:0] ad, int m);
    logic [7:0] b[4];
    b = '{ad[7:0], {4'h0, ad[11:8]}, ad[19:12], ad[27:20]};
    for (int j = 0; j < m; j++) ex(3'h1, b[j]);
  endtask

  // one command through the port, bounded waits on take and done
  task automatic issue(nbs_op_t op, logic [27:0] ad, logic [11:0] n);
    int k;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, addr: ad, len: n};
    busy_len  <= 8'($urandom_range(1, 90));
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20000) bad("command never finished");
    // the port must be free again in the cycle that reports completion
    n_tests++;
    if (cmd_ready !== 1'b1) bad("port not ready at done");
  endtask

  task automatic run_err(nbs_op_t op, logic [27:0] ad, logic [11:0] n);
    ex(3'h4, 8'h01);
    issue(op, ad, n);
  endtask

  task automatic rd_cmd(nbs_op_t op, logic [27:0] ad, logic [11:0] n,
                        logic [15:0] r, logic [11:0] c0);
    if (op == OP_READ) begin
      ex(3'h0, 8'h00);
      addr4(ad, 4);
      ex(3'h0, 8'h30);
    end
    if (op == OP_RAND) begin
      ex(3'h0, 8'h05);
      addr4(ad, 2);
      ex(3'h0, 8'he0);
    end
    if (op == OP_CACHE) ex(3'h0, 8'h31);
    if (op == OP_CACHE_END) ex(3'h0, 8'h3f);
    for (int j = 0; j < n; j++) ex(3'h3, pat(r, c0 + 12'(j)));
    ex(3'h4, 8'h00);
    issue(op, ad, n);
  endtask

  task automatic feed(logic [7:0] b);
    wq.push_back(b);
    pend.push_back(b);
  endtask

  task automatic prog(logic [27:0] ad, int n);
    ex(3'h0, 8'h80);
    addr4(ad, 4);
    for (int j = 0; j < n; j++) ex(3'h2, pend.pop_front());
    ex(3'h0, 8'h10);
    ex(3'h4, 8'h00);
    issue(OP_PROG, ad, 12'(n));
  endtask

  task automatic chk(logic [2:0] k, logic [7:0] b);
    nbs_ev_t e;
    n_tests++;
    if (q.size() == 0) begin
      bad("event with nothing expected");
    end else begin
      e = q.pop_front();
      if (e.k !== k || e.b !== b) bad("event differs from expected");
    end
  endtask

  // program data source: valid holds until taken, random gaps otherwise
  always @(posedge clock) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.delete(0);
    if (wr_valid !== 1'b1 || wr_ready === 1'b1) begin
      wr_valid <= wq.size() > 0 && $urandom_range(0, 3) != 0;
      wr_data  <= wq.size() > 0 ? wq[0] : 8'h00;
    end
  end

  // monitor: bus captures, read bytes and completions in order
  always @(posedge clock) begin
    if (arst_n) begin
      if (cap_v === 1'b1) chk({1'b0, cap_k}, cap_b);
      if (rd_valid === 1'b1) chk(3'h3, rd_data);
      if (done === 1'b1) chk(3'h4, {7'h00, err});
      if (viol === 1'b1) bad("strobe or data line misuse");
    end
  end

  initial begin
    #400000;
    bad("watchdog expired");
    wrap_up;
  end

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    busy_len = 8'h01;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(89));
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    a = {10'($urandom), 6'($urandom), 12'($urandom_range(0, 2170))};
    // refusals while nothing is loaded
    run_err(OP_RAND, a, 12'h001);
    run_err(OP_CACHE, a, 12'h001);
    run_err(OP_CACHE_END, a, 12'h001);
    run_err(nbs_op_t'(3'h7), a, 12'h001);
    run_err(OP_READ, a, 12'h881);
    run_err(OP_PROG, a, 12'h000);
    // page read, column move, two cache reads and the end command
    rd_cmd(OP_READ, a, 12'h003, a[27:12], a[11:0]);
    drow = a[27:12];
    a[11:0] = 12'($urandom_range(0, 2173));
    rd_cmd(OP_RAND, a, 12'h002, drow, a[11:0]);
    for (i = 0; i < 2; i++) begin
      orow = drow;
      drow = drow + 16'h0001;
      rd_cmd(OP_CACHE, a, 12'h002, orow, 12'h000);
    end
    rd_cmd(OP_CACHE_END, a, 12'h001, drow, 12'h000);
    // fill the data buffer ahead of the command until it refuses
    repeat (3) feed(8'($urandom));
    repeat (16) @(posedge clock);
    n_tests++;
    if (wr_ready !== 1'b0) bad("buffer accepted a third byte");
    a = {10'($urandom), 6'($urandom_range(1, 62)), 12'($urandom_range(0, 99))};
    prog(a, 3);
    for (i = 0; i < 3; i++) begin
      feed(8'($urandom));
      prog(a, 1);
    end
    run_err(OP_PROG, a, 12'h001);
    run_err(OP_PROG, a - 28'h0001000, 12'h001);
    run_err(OP_RAND, a, 12'h001);
    repeat (20) @(posedge clock);
    n_tests++;
    if (wr_ready !== 1'b1 || q.size() != 0 || wq.size() != 0)
      bad("events or data left over");
    wrap_up;
  end
endmodule
